// ===== hdl/bus_monitor_trigger_engine.sv
`timescale 1ns/100ps
module bus_monitor_trigger_engine
    import trig_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // register port
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // captured message side
    input wire logic MON_RUN,
    input wire logic MSG_END,
    input wire logic MSG_ERROR,
    output logic MSG_RD,
    output logic [7:0] MSG_ADDR,
    input wire logic [15:0] MSG_DATA,
    output result_s MSG_RESULT,
    output logic CAPTURE_WINDOW,
    // trigger pins
    input wire logic EXT_TRIG,
    output logic TRIG_OUT
);

    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam int EW = $clog2(EXT_MIN_CYC + 1);
    localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYCLES);
    localparam logic [EW-1:0] EXT_LAST = EW'(EXT_MIN_CYC - 1);

    // ****************************************************************
    // functions
    // ****************************************************************
    // one counting step: {reached zero, next counter}
    function automatic logic [16:0] count_step(input logic en, input logic [15:0] cnt,
                                               input logic [15:0] reload);
        logic [16:0] r;
        r = {1'b0, cnt};
        if (en) begin
            if (cnt <= 16'h0001) begin
                r = {1'b1, reload};
            end else begin
                r = {1'b0, cnt - 16'h0001};
            end
        end
        return r;
    endfunction

    // reserved control bits always read as zero
    function automatic event_ctrl_s ctrl_clean(input logic [31:0] w);
        event_ctrl_s c;
        c = event_ctrl_s'(w[15:0]);
        c.zero_hi = 8'h00;
        c.zero_mid = 1'b0;
        return c;
    endfunction

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [31:0] hdr;
    event_ctrl_s ctrl [2];
    logic [15:0] ev_loc [2][4];
    logic [15:0] ev_val [2][4];
    logic [15:0] ev_mask [2][4];
    logic [15:0] ev_rel [2][4];
    logic [15:0] ev_cnt [2][4];

    state_e state;
    logic [1:0] idx;
    logic side;
    logic err_l;
    logic [2:0] match;
    logic ext_pend;
    logic [EW-1:0] ext_hi;
    logic [PW-1:0] pulse_cnt;

    logic commit;
    logic side_on;
    logic ok;
    logic pm;
    logic [2:0] mv;
    logic [2:0] step;
    logic [2:0] hit;
    logic [2:0] f;
    logic [2:0] nf;
    logic [15:0] next_cnt [3];
    logic fire_seq;
    logic fire_ext;
    logic fire;
    logic next_cwe;
    logic [31:0] next_rdata;

    wire logic ev_sel = (REG_ADDR[11:8] == EVT_REGION);
    wire logic ev_side = REG_ADDR[7];
    wire logic [1:0] ev_slot = REG_ADDR[6:5];
    wire logic [2:0] ev_word = REG_ADDR[4:2];

    assign commit = (state == ST_COMMIT);
    assign CAPTURE_WINDOW = hdr[HB_CWE];
    assign MSG_RD = (state == ST_FETCH);

    // ****************************************************************
    // message sequencer
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            idx <= 2'd0;
            side <= 1'b0;
            err_l <= 1'b0;
            match <= 3'b000;
            MSG_ADDR <= 8'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (MSG_END) begin
                        side <= hdr[HB_CWE];
                        err_l <= MSG_ERROR;
                        idx <= 2'd0;
                        match <= 3'b000;
                        MSG_ADDR <= ev_loc[hdr[HB_CWE]][0][7:0];
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    state <= ST_CHECK;
                end
                ST_CHECK: begin
                    // zero location marks an unused slot
                    match[idx] <= (ev_loc[side][idx] != WORD_RESET)
                        && (((MSG_DATA ^ ev_val[side][idx]) & ev_mask[side][idx])
                            == WORD_RESET);
                    if (idx == 2'd2) begin
                        state <= ST_COMMIT;
                    end else begin
                        idx <= idx + 2'd1;
                        MSG_ADDR <= ev_loc[side][idx + 2'd1][7:0];
                        state <= ST_FETCH;
                    end
                end
                ST_COMMIT: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // trigger evaluation
    // ****************************************************************
    always_comb begin
        side_on = side ? (hdr[HB_STOP] & hdr[HB_CWE])
            : (hdr[HB_START] & ~hdr[HB_CWE]);
        f = ctrl[side].done;
        ok = ~err_l | hdr[HB_TERR];
        mv = ok ? match : 3'b000;
        pm = mv[0] & mv[1];
        step = mv;
        unique case (ctrl[side].func)
            CR_PAIR, CR_PAIR_AND3, CR_PAIR_OR3: step[1:0] = {pm, pm};
            CR_3_BY_PAIR: begin
                step[1:0] = {pm, pm};
                step[2] = mv[2] & f[0] & f[1];
            end
            CR_PAIR_BY_3: step[1:0] = {2{pm & f[2]}};
            CR_2_BY_1: step[1] = mv[1] & f[0];
            default: step = mv;
        endcase
        if (!side_on) begin
            step = 3'b000;
        end
        for (int i = 0; i < 3; i++) begin
            {hit[i], next_cnt[i]} = count_step(step[i], ev_cnt[side][i], ev_rel[side][i]);
        end
        nf = f | hit;
        unique case (ctrl[side].func)
            CR_AUTO: fire_seq = ok;
            CR_SINGLE: fire_seq = nf[0];
            CR_PAIR, CR_AND12, CR_PAIR_BY_3: fire_seq = nf[0] & nf[1];
            CR_PAIR_AND3, CR_AND123: fire_seq = &nf;
            CR_PAIR_OR3: fire_seq = (nf[0] & nf[1]) | nf[2];
            CR_3_BY_PAIR: fire_seq = nf[2];
            CR_OR123: fire_seq = |nf;
            CR_2_BY_1: fire_seq = nf[1];
            CR_OR12: fire_seq = nf[0] | nf[1];
            default: fire_seq = 1'b0;
        endcase
        fire_seq = fire_seq & side_on;
        fire_ext = ext_pend & hdr[HB_EXT];
        fire = fire_seq | fire_ext;
        next_cwe = fire ? ~hdr[HB_CWE] : hdr[HB_CWE];
    end

    // ****************************************************************
    // registers written by software and hardware
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hdr <= HDR_RESET;
        end else begin
            if (REG_WR && REG_ADDR == HDR_OFS) begin
                hdr <= REG_WDATA & HDR_WMASK;
            end
            if (commit) begin
                hdr[HB_CWE] <= next_cwe;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl[0] <= event_ctrl_s'(WORD_RESET);
            ctrl[1] <= event_ctrl_s'(WORD_RESET);
        end else begin
            if (REG_WR && REG_ADDR == START_CTRL_OFS) begin
                ctrl[0] <= ctrl_clean(REG_WDATA);
            end
            if (REG_WR && REG_ADDR == STOP_CTRL_OFS) begin
                ctrl[1] <= ctrl_clean(REG_WDATA);
            end
            if (commit && side_on) begin
                ctrl[side].done <= fire ? 3'b000 : nf;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int s = 0; s < 2; s++) begin
                for (int k = 0; k < 4; k++) begin
                    ev_loc[s][k] <= WORD_RESET;
                    ev_val[s][k] <= WORD_RESET;
                    ev_mask[s][k] <= MASK_RESET;
                    ev_rel[s][k] <= WORD_RESET;
                    ev_cnt[s][k] <= WORD_RESET;
                end
            end
        end else begin
            if (REG_WR && ev_sel) begin
                unique case (ev_word)
                    EW_LOC: ev_loc[ev_side][ev_slot] <= REG_WDATA[15:0];
                    EW_VALUE: ev_val[ev_side][ev_slot] <= REG_WDATA[15:0];
                    EW_MASK: ev_mask[ev_side][ev_slot] <= REG_WDATA[15:0];
                    EW_RELOAD: ev_rel[ev_side][ev_slot] <= REG_WDATA[15:0];
                    EW_COUNT: ev_cnt[ev_side][ev_slot] <= REG_WDATA[15:0];
                    default: ;
                endcase
            end
            if (commit) begin
                for (int i = 0; i < 3; i++) begin
                    ev_cnt[side][i] <= next_cnt[i];
                end
            end
        end
    end

    // ****************************************************************
    // external trigger input
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_hi <= '0;
        end else if (!EXT_TRIG) begin
            ext_hi <= '0;
        end else if (ext_hi != EXT_LAST) begin
            ext_hi <= ext_hi + EW'(1);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ext_pend <= 1'b0;
        end else if (EXT_TRIG && ext_hi == EXT_LAST && hdr[HB_EXT]) begin
            ext_pend <= 1'b1;
        end else if (commit || !MON_RUN) begin
            ext_pend <= 1'b0;
        end
    end

    // ****************************************************************
    // trigger output pulse
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_cnt <= '0;
            TRIG_OUT <= 1'b0;
        end else if (commit && fire && hdr[HB_XOT]) begin
            pulse_cnt <= PULSE_LOAD;
            TRIG_OUT <= 1'b1;
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - PW'(1);
            TRIG_OUT <= (pulse_cnt > PW'(1));
        end else begin
            TRIG_OUT <= 1'b0;
        end
    end

    // ****************************************************************
    // per-message result
    // ****************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            MSG_RESULT <= '0;
        end else begin
            MSG_RESULT.done <= commit;
            MSG_RESULT.fired <= commit & fire;
            MSG_RESULT.report <= commit & (hdr[HB_CWE] | next_cwe);
        end
    end

    // ****************************************************************
    // register read
    // ****************************************************************
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (ev_sel) begin
            unique case (ev_word)
                EW_LOC: next_rdata = {16'h0000, ev_loc[ev_side][ev_slot]};
                EW_VALUE: next_rdata = {16'h0000, ev_val[ev_side][ev_slot]};
                EW_MASK: next_rdata = {16'h0000, ev_mask[ev_side][ev_slot]};
                EW_RELOAD: next_rdata = {16'h0000, ev_rel[ev_side][ev_slot]};
                EW_COUNT: next_rdata = {16'h0000, ev_cnt[ev_side][ev_slot]};
                default: next_rdata = 32'h0000_0000;
            endcase
        end else if (REG_ADDR == HDR_OFS) begin
            next_rdata = hdr;
        end else if (REG_ADDR == START_CTRL_OFS) begin
            next_rdata = {16'h0000, ctrl[0]};
        end else if (REG_ADDR == STOP_CTRL_OFS) begin
            next_rdata = {16'h0000, ctrl[1]};
        end else if (REG_ADDR == STATUS_OFS) begin
            next_rdata = {29'h0000_0000, state != ST_IDLE, TRIG_OUT, ext_pend};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            REG_RDATA <= next_rdata;
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

endmodule // bus_monitor_trigger_engine

// ===== hdl/trig_pkg.sv
package trig_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int EXT_MIN_NS = 400;
    localparam int EXT_MIN_CYC = (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_US = 50;
    localparam int PULSE_CYC = (PULSE_US * 1000) / CLK_PERIOD_NS;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] HDR_OFS = 12'h000;
    localparam logic [11:0] START_CTRL_OFS = 12'h004;
    localparam logic [11:0] STOP_CTRL_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00c;
    // event slots: addr[11:8] region, addr[7] side, addr[6:5] slot, addr[4:2] word
    localparam logic [3:0] EVT_REGION = 4'h1;
    localparam logic [2:0] EW_LOC = 3'h0;
    localparam logic [2:0] EW_VALUE = 3'h1;
    localparam logic [2:0] EW_MASK = 3'h2;
    localparam logic [2:0] EW_RELOAD = 3'h3;
    localparam logic [2:0] EW_COUNT = 3'h4;

    // header bits
    localparam int HB_CWE = 0;
    localparam int HB_START = 1;
    localparam int HB_STOP = 2;
    localparam int HB_EXT = 4;
    localparam int HB_TERR = 5;
    localparam int HB_XOT = 7;
    localparam logic [31:0] HDR_WMASK = 32'h0000_00b7;
    localparam logic [31:0] HDR_RESET = 32'h0000_0000;
    localparam logic [15:0] MASK_RESET = 16'hffff;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        CR_AUTO = 4'h0, CR_SINGLE = 4'h1, CR_PAIR = 4'h2, CR_AND12 = 4'h3,
        CR_PAIR_AND3 = 4'h4, CR_PAIR_OR3 = 4'h5, CR_3_BY_PAIR = 4'h6,
        CR_PAIR_BY_3 = 4'h7, CR_AND123 = 4'h8, CR_OR123 = 4'h9,
        CR_2_BY_1 = 4'ha, CR_OR12 = 4'hb
    } criteria_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_FETCH = 4'b0010, ST_CHECK = 4'b0100, ST_COMMIT = 4'b1000
    } state_e;

    typedef struct packed {
        logic [7:0] zero_hi;
        logic [3:0] func;
        logic zero_mid;
        logic [2:0] done;
    } event_ctrl_s;

    typedef struct packed {
        logic done;
        logic fired;
        logic report;
    } result_s;

endpackage

// ===== tb/msg_record_model.sv
`timescale 1ns/100ps
module msg_record_model (
    // clock
    input wire logic sys_clk,
    // fetch request
    input wire logic msg_rd,
    input wire logic [7:0] msg_addr,
    // word returned
    output logic [15:0] msg_data
);
    logic [15:0] mem [0:255];
    initial begin
        msg_data = 16'h0;
        foreach (mem[i]) mem[i] = 16'h0;
    end
    // fetched word stands one cycle, then the lines keep changing
    always @(posedge sys_clk) begin
        if (msg_rd) begin
            msg_data <= mem[msg_addr];
        end else begin
            msg_data <= ~msg_data;
        end
    end
endmodule // msg_record_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import trig_pkg::*;
    localparam int PULSE_N = 20;
    logic sys_clk, rst_n, wr_stb, rd_stb, mon_run, msg_end, msg_error, ext_trig;
    logic msg_rd, capture_window, trig_out;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0] msg_addr;
    logic [15:0] msg_data;
    result_s msg_result, res;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;

    bus_monitor_trigger_engine #(.PULSE_CYCLES(PULSE_N)) dut_u (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(wr_stb), .REG_RD(rd_stb), .REG_RDATA(reg_rdata), .MON_RUN(mon_run),
        .MSG_END(msg_end), .MSG_ERROR(msg_error), .MSG_RD(msg_rd), .MSG_ADDR(msg_addr),
        .MSG_DATA(msg_data), .MSG_RESULT(msg_result), .CAPTURE_WINDOW(capture_window),
        .EXT_TRIG(ext_trig), .TRIG_OUT(trig_out)
    );
    msg_record_model rec_u (
        .sys_clk(sys_clk), .msg_rd(msg_rd), .msg_addr(msg_addr), .msg_data(msg_data)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
        @(posedge sys_clk);
        reg_addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(negedge sys_clk);
        check(name, reg_rdata, exp);
    endtask
    function automatic logic [11:0] ev(input int side, input int slot, input int word);
        return 12'(256 + side * 128 + slot * 32 + word * 4);
    endfunction
    task automatic set_ev(input int side, slot, input logic [15:0] loc, val, msk, cnt);
        reg_wr(ev(side, slot, EW_LOC), {16'h0, loc});
        reg_wr(ev(side, slot, EW_VALUE), {16'h0, val});
        reg_wr(ev(side, slot, EW_MASK), {16'h0, msk});
        reg_wr(ev(side, slot, EW_RELOAD), {16'h0, cnt});
        reg_wr(ev(side, slot, EW_COUNT), {16'h0, cnt});
    endtask
    // command, status and first data word of the next captured message
    task automatic msg(input logic [15:0] w10, w1c, w28, input logic err);
        rec_u.mem[8'h10] = w10;
        rec_u.mem[8'h1c] = w1c;
        rec_u.mem[8'h28] = w28;
        @(posedge sys_clk);
        msg_end <= 1'b1;
        msg_error <= err;
        @(posedge sys_clk);
        msg_end <= 1'b0;
        msg_error <= 1'b0;
        res = '0;
        for (int i = 0; i < 12 && res.done !== 1'b1; i++) begin
            @(negedge sys_clk);
            res = msg_result;
        end
        check("done", res.done, 1'b1);
    endtask
    task automatic ext_pulse(input int n);
        @(posedge sys_clk);
        ext_trig <= 1'b1;
        repeat (n) @(posedge sys_clk);
        ext_trig <= 1'b0;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0;
        {wr_stb, rd_stb, msg_end, msg_error, ext_trig} = 5'h0;
        mon_run = 1'b1;
        reg_addr = 12'h0;
        reg_wdata = 32'h0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        check("trig idle", trig_out, 1'b0);
        rd_chk(HDR_OFS, 32'h0, "header");
        rd_chk(ev(1, 3, EW_MASK), 32'hffff, "mask");
        reg_wr(HDR_OFS, 32'hffff_ffff);
        rd_chk(HDR_OFS, 32'h0000_00b7, "header bits");
        reg_wr(START_CTRL_OFS, 32'hffff_ffff);
        rd_chk(START_CTRL_OFS, 32'h0000_00f7, "ctrl bits");
        reg_wr(12'h0fc, 32'h1234_5678);
        rd_chk(12'h0fc, 32'h0, "unmapped");
        reg_wr(START_CTRL_OFS, 32'h0);
        reg_wr(HDR_OFS, 32'h1);
        msg(16'h0, 16'h0, 16'h0, 1'b0);
        check("report on", res.report, 1'b1);
        reg_wr(HDR_OFS, 32'h0);
        msg(16'h0, 16'h0, 16'h0, 1'b0);
        check("report off", res.report, 1'b0);
        // start side, single event, two occurrences, masked compare
        set_ev(0, 0, 16'h10, 16'h0821, 16'hf800, 16'h2);
        reg_wr(START_CTRL_OFS, 32'h10);
        reg_wr(HDR_OFS, 32'h82);
        msg(16'h1821, 16'h0, 16'h0, 1'b0);
        rd_chk(ev(0, 0, EW_COUNT), 32'h2, "no match");
        msg(16'h0825, 16'h0, 16'h0, 1'b1);
        rd_chk(ev(0, 0, EW_COUNT), 32'h2, "errored");
        msg(16'h0825, 16'h0, 16'h0, 1'b0);
        rd_chk(ev(0, 0, EW_COUNT), 32'h1, "count down");
        msg(16'h0825, 16'h0, 16'h0, 1'b0);
        check("start fired", res.fired, 1'b1);
        check("window set", capture_window, 1'b1);
        check("trig out", trig_out, 1'b1);
        rd_chk(STATUS_OFS, 32'h2, "pulse status");
        rd_chk(START_CTRL_OFS, 32'h10, "flags cleared");
        rd_chk(ev(0, 0, EW_COUNT), 32'h2, "reload");
        repeat (PULSE_N + 2) @(posedge sys_clk);
        // stop side, event 1 and event 2 on different messages
        set_ev(1, 0, 16'h28, 16'h1234, 16'hffff, 16'h1);
        set_ev(1, 1, 16'h1c, 16'h0800, 16'hffff, 16'h1);
        reg_wr(STOP_CTRL_OFS, 32'h30);
        reg_wr(HDR_OFS, 32'h25);
        msg(16'h0, 16'h0, 16'h1234, 1'b1);
        rd_chk(STOP_CTRL_OFS, 32'h31, "error match");
        msg(16'h0, 16'h0800, 16'h0, 1'b0);
        check("stop fired", res.fired, 1'b1);
        check("window clr", capture_window, 1'b0);
        msg(16'h0, 16'h0800, 16'h1234, 1'b0);
        check("stop idle", res.fired, 1'b0);
        // every criteria code: event 1 and 3 match, event 2 does not
        set_ev(0, 0, 16'h10, 16'h0821, 16'hffff, 16'h1);
        set_ev(0, 1, 16'h1c, 16'h0800, 16'hffff, 16'h1);
        set_ev(0, 2, 16'h28, 16'h1234, 16'hffff, 16'h1);
        for (int c = 0; c < 16; c++) begin
            reg_wr(START_CTRL_OFS, 32'(c * 16));
            reg_wr(HDR_OFS, 32'h2);
            msg(16'h0821, 16'h0, 16'h1234, 1'b0);
            check("criteria", res.fired, 1'((16'h0a23 >> c) & 1));
        end
        // event 2 armed by event 1
        set_ev(0, 0, 16'h10, 16'h0821, 16'hffff, 16'h2);
        reg_wr(ev(0, 2, EW_LOC), 32'h0);
        reg_wr(START_CTRL_OFS, 32'ha0);
        reg_wr(HDR_OFS, 32'h2);
        msg(16'h0, 16'h0800, 16'h0, 1'b0);
        rd_chk(ev(0, 1, EW_COUNT), 32'h1, "unarmed");
        repeat (2) msg(16'h0821, 16'h0, 16'h0, 1'b0);
        rd_chk(START_CTRL_OFS, 32'ha1, "armed");
        msg(16'h0, 16'h0800, 16'h0, 1'b0);
        check("armed fired", res.fired, 1'b1);
        // external trigger
        reg_wr(HDR_OFS, 32'h10);
        ext_pulse(EXT_MIN_CYC - 1);
        rd_chk(STATUS_OFS, 32'h0, "short pulse");
        ext_pulse(EXT_MIN_CYC);
        rd_chk(STATUS_OFS, 32'h1, "ext held");
        @(posedge sys_clk);
        mon_run <= 1'b0;
        @(posedge sys_clk);
        mon_run <= 1'b1;
        rd_chk(STATUS_OFS, 32'h0, "run off");
        ext_pulse(EXT_MIN_CYC);
        msg(16'h0, 16'h0, 16'h0, 1'b0);
        check("ext fired", res.fired, 1'b1);
        check("ext window", capture_window, 1'b1);
        rd_chk(STATUS_OFS, 32'h0, "ext cleared");
        ext_pulse(EXT_MIN_CYC);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(STATUS_OFS, 32'h0, "reset clears");
        stop_test();
    end
endmodule // tb_top

// ===== tb/trig_engine_properties.sv
`timescale 1ns/100ps
module trig_engine_checker
    import trig_pkg::*;
#(
    parameter int PULSE_CYCLES = 20
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // register port
    input wire logic REG_WR,
    input wire logic [31:0] REG_RDATA,
    // message side
    input wire logic MSG_END,
    input wire logic MSG_RD,
    input wire result_s MSG_RESULT,
    input wire logic CAPTURE_WINDOW,
    // trigger pin
    input wire logic TRIG_OUT
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    // ****************************************************************
    // helper counters: evaluation phase and output pulse length
    // ****************************************************************
    logic [3:0] busy_cnt;
    logic [15:0] hi_cnt;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_cnt <= 4'h0;
        end else if (MSG_END && busy_cnt == 4'h0) begin
            busy_cnt <= 4'h7;
        end else if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
        end
    end
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hi_cnt <= 16'h0;
        end else begin
            hi_cnt <= TRIG_OUT ? hi_cnt + 16'h1 : 16'h0;
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    sequence s_fetch3;
        MSG_RD ##1 !MSG_RD ##1 MSG_RD ##1 !MSG_RD ##1 MSG_RD ##1 !MSG_RD;
    endsequence
    sequence s_commit;
        !MSG_RD && !MSG_RESULT.done ##1 MSG_RESULT.done;
    endsequence
    property p_walk;
        MSG_END && busy_cnt == 4'h0 |=> s_fetch3 ##1 s_commit;
    endproperty
    a_walk: assert property (p_walk)
        else $error("message evaluation walk out of step");
    property p_done_cause;
        MSG_RESULT.done |-> $past(MSG_END, 8);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("result without a message end eight cycles before");
    property p_rd_slots;
        MSG_RD |-> busy_cnt inside {4'h7, 4'h5, 4'h3};
    endproperty
    a_rd_slots: assert property (p_rd_slots)
        else $error("word fetch outside the three event slots");
    property p_fired_done;
        MSG_RESULT.fired |-> MSG_RESULT.done;
    endproperty
    a_fired_done: assert property (p_fired_done)
        else $error("trigger flagged outside a result");
    property p_toggle;
        MSG_RESULT.done |-> (CAPTURE_WINDOW != $past(CAPTURE_WINDOW)) == MSG_RESULT.fired;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("window change does not match trigger");
    property p_window_src;
        $changed(CAPTURE_WINDOW) |-> $past(REG_WR) || MSG_RESULT.done;
    endproperty
    a_window_src: assert property (p_window_src)
        else $error("window moved without write or commit");
    property p_pulse_rise;
        $rose(TRIG_OUT) |-> MSG_RESULT.fired;
    endproperty
    a_pulse_rise: assert property (p_pulse_rise)
        else $error("output pulse without trigger");
    property p_pulse_len;
        $fell(TRIG_OUT) |-> hi_cnt == 16'(PULSE_CYCLES);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("output pulse length wrong");
    property p_reset_idle;
        $rose(RST_N) |-> !TRIG_OUT && !CAPTURE_WINDOW && REG_RDATA == 32'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");
endmodule // trig_engine_checker

bind bus_monitor_trigger_engine trig_engine_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
    .MSG_END(MSG_END), .MSG_RD(MSG_RD), .MSG_RESULT(MSG_RESULT),
    .CAPTURE_WINDOW(CAPTURE_WINDOW), .TRIG_OUT(TRIG_OUT)
);
